// File: fccl_flag_unit.sv
`timescale 1ns/1ps
module fccl_flag_unit
    import fccl_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Datapath request
    input  wire logic        upd_valid,
    input  wire fccl_req_t   upd_req,
    // Datapath results
    output logic             res_valid,
    output logic [31:0]      res_data,
    output fccl_flags_t      live_flags,
    output logic [15:0]      keys_copy,
    output fccl_cond_t       cond,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);

    // ==========================================================
    // State
    fccl_flags_t  flags_r;
    fccl_flags_t  flags_nxt;
    logic [15:0]  keys_r;
    logic [31:0]  res_r;
    logic         res_valid_r;
    logic         bvalid_r;
    logic [1:0]   bresp_r;
    logic         rvalid_r;
    logic [31:0]  rdata_r;
    logic [1:0]   rresp_r;

    // ==========================================================
    // Operand extension to one bit beyond 32-bit width
    wire logic [32:0] ext_a;
    wire logic [32:0] ext_b;
    wire logic [32:0] u_a;
    wire logic [32:0] u_b;
    wire logic [32:0] u_mask;
    wire logic [32:0] sum_ext;
    wire logic [32:0] dif_ext;
    wire logic [32:0] u_sum;
    wire logic [32:0] u_dif;
    wire logic [31:0] width_mask;

    assign width_mask = upd_req.wide ? 32'hFFFFFFFF : 32'h0000FFFF;
    assign ext_a  = upd_req.wide ? {upd_req.a[31], upd_req.a}
                                 : {{17{upd_req.a[15]}}, upd_req.a[15:0]};
    assign ext_b  = upd_req.wide ? {upd_req.b[31], upd_req.b}
                                 : {{17{upd_req.b[15]}}, upd_req.b[15:0]};
    assign u_a    = {1'b0, upd_req.a & width_mask};
    assign u_b    = {1'b0, upd_req.b & width_mask};
    assign u_mask = {1'b0, width_mask};
    assign sum_ext = ext_a + ext_b;
    assign dif_ext = ext_a - ext_b;
    assign u_sum   = u_a + u_b;
    assign u_dif   = u_a + (u_b ^ u_mask) + 33'h000000001;

    // ==========================================================
    // Result values
    wire logic [31:0] arith_res;
    wire logic [31:0] logic_res;
    wire logic [31:0] sel_res;
    wire logic        is_sub;
    wire logic        arith_carry;
    wire logic        res_msb;
    wire logic        res_zero;
    wire logic        ext_sign;
    wire logic [31:0] logic_raw;

    assign is_sub    = (upd_req.op == op_sub);
    assign arith_res = (is_sub ? dif_ext[31:0] : sum_ext[31:0]) & width_mask;
    assign logic_raw = (upd_req.fn == fn_and) ? (upd_req.a & upd_req.b) :
                       (upd_req.fn == fn_or)  ? (upd_req.a | upd_req.b) :
                       (upd_req.fn == fn_xor) ? (upd_req.a ^ upd_req.b) :
                                                ~upd_req.a;
    assign logic_res = logic_raw & width_mask;
    assign sel_res   = (upd_req.op == op_logic) ? logic_res :
                       (upd_req.op == op_cmp)   ? (dif_ext[31:0] & width_mask) :
                                                  arith_res;
    assign res_zero  = (sel_res == 32'h00000000);
    assign res_msb   = upd_req.wide ? sel_res[31] : sel_res[15];
    assign ext_sign  = (is_sub || upd_req.op == op_cmp) ? dif_ext[32] : sum_ext[32];
    assign arith_carry = upd_req.wide ? (is_sub ? u_dif[32] : u_sum[32])
                                      : (is_sub ? u_dif[16] : u_sum[16]);

    // ==========================================================
    // AXI4-Lite decode
    wire logic        wr_go;
    wire logic        rd_go;
    wire logic        wr_cmd_hit;
    wire logic        wr_hit;
    wire logic [1:0]  sw_cmd;
    wire logic [15:0] sw_keys;
    wire logic        rd_hit;
    wire logic [31:0] rd_word;

    // Bus writes wait while the datapath updates the flags, so no update is lost.
    assign wr_go   = s_axi_awvalid && s_axi_wvalid && !bvalid_r && !upd_valid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign wr_hit  = (s_axi_awaddr == FCCL_CMD_OFS);
    assign wr_cmd_hit = wr_go && wr_hit && s_axi_wstrb[2];
    assign sw_cmd  = wr_cmd_hit ? s_axi_wdata[FCCL_CMD_LSB +: 2] : FCCL_SW_NONE;
    assign sw_keys = s_axi_wdata[15:0];

    assign rd_go   = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = rd_go;
    assign rd_hit  = (s_axi_araddr == FCCL_CMD_OFS) || (s_axi_araddr == FCCL_LIVE_OFS) ||
                     (s_axi_araddr == FCCL_KEYS_OFS) || (s_axi_araddr == FCCL_COND_OFS);
    assign rd_word = (s_axi_araddr == FCCL_LIVE_OFS) ? {28'h0000000, flags_r} :
                     (s_axi_araddr == FCCL_KEYS_OFS) ? {16'h0000, keys_r} :
                     (s_axi_araddr == FCCL_COND_OFS) ? {26'h0000000, cond} :
                                                       32'h00000000;

    // ==========================================================
    // Flag update
    always_comb begin
        flags_nxt = flags_r;
        if (upd_valid) begin
            case (upd_req.op)
                op_add, op_sub: begin
                    flags_nxt.ovf   = (ext_sign != res_msb);
                    flags_nxt.carry = arith_carry;
                    flags_nxt.sign  = ext_sign;
                    flags_nxt.zero  = res_zero;
                end
                op_cmp: begin
                    flags_nxt.sign  = ext_sign;
                    flags_nxt.zero  = res_zero;
                end
                op_logic: begin
                    flags_nxt.sign  = res_msb;
                    flags_nxt.zero  = res_zero;
                end
                op_fault: begin
                    flags_nxt.ovf   = 1'b1;
                end
                clear_overflow_flag_op: begin
                    flags_nxt.ovf   = 1'b0;
                end
                set_overflow_flag_op: begin
                    flags_nxt.ovf   = 1'b1;
                end
                accumulator_to_flags_op, load_status_word_op: begin
                    flags_nxt.ovf   = upd_req.a[FCCL_KEY_OVF];
                    flags_nxt.carry = upd_req.a[FCCL_KEY_CARRY];
                    flags_nxt.sign  = upd_req.a[FCCL_KEY_SIGN];
                    flags_nxt.zero  = upd_req.a[FCCL_KEY_ZERO];
                end
                default: begin
                    flags_nxt = flags_r;
                end
            endcase
        end else begin
            case (sw_cmd)
                FCCL_SW_CLR: begin
                    flags_nxt.ovf = 1'b0;
                end
                FCCL_SW_SET: begin
                    flags_nxt.ovf = 1'b1;
                end
                FCCL_SW_LOAD: begin
                    flags_nxt.ovf   = sw_keys[FCCL_KEY_OVF];
                    flags_nxt.carry = sw_keys[FCCL_KEY_CARRY];
                    flags_nxt.sign  = sw_keys[FCCL_KEY_SIGN];
                    flags_nxt.zero  = sw_keys[FCCL_KEY_ZERO];
                end
                default: begin
                    flags_nxt = flags_r;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_r <= FCCL_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            keys_r <= FCCL_KEYS_RST;
        end else begin
            keys_r                 <= FCCL_KEYS_RST;
            keys_r[FCCL_KEY_OVF]   <= flags_r.ovf;
            keys_r[FCCL_KEY_CARRY] <= flags_r.carry;
            keys_r[FCCL_KEY_SIGN]  <= flags_r.sign;
            keys_r[FCCL_KEY_ZERO]  <= flags_r.zero;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_r       <= 32'h00000000;
            res_valid_r <= 1'b0;
        end else begin
            res_valid_r <= upd_valid && (upd_req.op == op_add || upd_req.op == op_sub ||
                                         upd_req.op == op_logic);
            if (upd_valid) begin
                res_r <= sel_res;
            end
        end
    end

    // ==========================================================
    // Bus answers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r  <= FCCL_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? FCCL_RESP_OKAY : FCCL_RESP_SLV;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= FCCL_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? FCCL_RESP_OKAY : FCCL_RESP_SLV;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    assign res_valid    = res_valid_r;
    assign res_data     = res_r;
    assign live_flags   = flags_r;
    assign keys_copy    = keys_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp  = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata  = rdata_r;
    assign s_axi_rresp  = rresp_r;

    assign cond = '{gt: !flags_r.sign && !flags_r.zero,
                    eq: flags_r.zero,
                    lt: flags_r.sign,
                    ge: !flags_r.sign,
                    le: flags_r.sign || flags_r.zero,
                    ne: !flags_r.zero};

endmodule

// File: fccl_pkg.sv
package fccl_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  FCCL_CMD_OFS    = 4'h0;
    localparam logic [3:0]  FCCL_LIVE_OFS   = 4'h4;
    localparam logic [3:0]  FCCL_KEYS_OFS   = 4'h8;
    localparam logic [3:0]  FCCL_COND_OFS   = 4'hC;

    // ==========================================================
    // Field positions in the 16-bit keys image, bit 15 is the MSB, and the low bit of the command field in CMD
    localparam int          FCCL_KEY_OVF    = 15;
    localparam int          FCCL_KEY_CARRY  = 13;
    localparam int          FCCL_KEY_SIGN   = 7;
    localparam int          FCCL_KEY_ZERO   = 6;
    localparam int          FCCL_CMD_LSB    = 16;

    // ==========================================================
    // Reset values and answers
    localparam logic [3:0]  FCCL_FLAGS_RST  = 4'h0;
    localparam logic [15:0] FCCL_KEYS_RST   = 16'h0000;
    localparam logic [1:0]  FCCL_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  FCCL_RESP_SLV   = 2'h2;

    // ==========================================================
    // Software commands in CMD[17:16]
    localparam logic [1:0]  FCCL_SW_NONE    = 2'h0;
    localparam logic [1:0]  FCCL_SW_CLR     = 2'h1;
    localparam logic [1:0]  FCCL_SW_SET     = 2'h2;
    localparam logic [1:0]  FCCL_SW_LOAD    = 2'h3;

    typedef enum logic [3:0] {
        op_add,
        op_sub,
        op_cmp,
        op_logic,
        op_fault,
        clear_overflow_flag_op,
        set_overflow_flag_op,
        accumulator_to_flags_op,
        load_status_word_op
    } fccl_op_t;

    typedef enum logic [1:0] {
        fn_and,
        fn_or,
        fn_xor,
        fn_cpl
    } fccl_logic_fn_t;

    typedef struct packed {
        fccl_op_t       op;
        fccl_logic_fn_t fn;
        logic           wide;
        logic [31:0]    a;
        logic [31:0]    b;
    } fccl_req_t;

    typedef struct packed {
        logic ovf;
        logic carry;
        logic sign;
        logic zero;
    } fccl_flags_t;

    typedef struct packed {
        logic gt;
        logic eq;
        logic lt;
        logic ge;
        logic le;
        logic ne;
    } fccl_cond_t;

endpackage

// File: fccl_flag_unit_asserts.sv
`timescale 1ns/1ps
module fccl_flag_unit_asserts
    import fccl_pkg::*;
(
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Datapath side
    input wire logic        upd_valid,
    input wire fccl_req_t   upd_req,
    input wire logic        res_valid,
    input wire logic [31:0] res_data,
    input wire fccl_flags_t live_flags,
    input wire logic [15:0] keys_copy,
    input wire fccl_cond_t  cond
);
    // ========
    // Reference terms
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [32:0] sum  = {1'h0, upd_req.a} + {1'h0, upd_req.b};
    wire logic        ovf  = (upd_req.a[31] == upd_req.b[31]) && (sum[31] != upd_req.a[31]);
    wire logic        xsgn = upd_req.a[31] ^ upd_req.b[31] ^ sum[32];
    wire logic        lt32 = $signed(upd_req.a) < $signed(upd_req.b);
    wire logic        eq32 = upd_req.a == upd_req.b;
    wire logic        due  = upd_valid && (upd_req.op inside {op_add, op_sub, op_logic});
    wire logic [15:0] kimg = {live_flags.ovf, 1'h0, live_flags.carry, 5'h00,
                              live_flags.sign, live_flags.zero, 6'h00};
    sequence s_op(fccl_op_t o);
        upd_valid && upd_req.op == o;
    endsequence

    // ========
    // Checks
    res_pulse_a: assert property (res_valid == $past(due))
        else $error("result strobe out of step");
    keys_lag_a: assert property (keys_copy == $past(kimg))
        else $error("keys copy does not trail live flags");
    clr_ovf_a: assert property (s_op(clear_overflow_flag_op) |=> !live_flags.ovf)
        else $error("overflow flag not cleared");
    set_ovf_a: assert property (s_op(set_overflow_flag_op) |=> live_flags.ovf)
        else $error("overflow flag not set");
    fault_ovf_a: assert property (s_op(op_fault) |=> live_flags.ovf && $stable(live_flags[2:0]))
        else $error("fault did not raise only the overflow flag");
    zero_bit_a: assert property (res_valid |-> live_flags.zero == (res_data == 32'h00000000))
        else $error("zero bit disagrees with result");
    logic_sign_a: assert property (s_op(op_logic) |=>
        live_flags.sign == ($past(upd_req.wide) ? res_data[31] : res_data[15]))
        else $error("logic sign is not the result top bit");
    cmp_code_a: assert property (s_op(op_cmp) |=> !$past(upd_req.wide) ||
        (live_flags.sign == $past(lt32) && live_flags.zero == $past(eq32)))
        else $error("compare codes wrong");
    add_flags_a: assert property (s_op(op_add) |=> !$past(upd_req.wide) ||
        (live_flags.ovf == $past(ovf) && live_flags.carry == $past(sum[32]) && live_flags.sign == $past(xsgn)))
        else $error("add flags wrong");
    cond_map_a: assert property (cond.lt == live_flags.sign && cond.eq == live_flags.zero &&
        cond.ne == !live_flags.zero && cond.ge == !live_flags.sign &&
        cond.gt == (!live_flags.sign && !live_flags.zero) && cond.le == (live_flags.sign || live_flags.zero))
        else $error("condition outputs disagree with live flags");
endmodule

bind fccl_flag_unit fccl_flag_unit_asserts fccl_flag_unit_asserts_i (
    .aclk, .aresetn, .upd_valid, .upd_req, .res_valid, .res_data, .live_flags, .keys_copy, .cond
);

// File: fccl_datapath_model.sv
`timescale 1ns/1ps
module fccl_datapath_model
    import fccl_pkg::*;
(
    // Clock
    input wire logic  aclk,
    // Request to the flag unit
    output logic      upd_valid,
    output fccl_req_t upd_req,
    // Codes back for branching
    input wire fccl_cond_t cond
);
    initial begin
        upd_valid = 1'h0;
        upd_req = '0;
    end
    // Issues one instruction for one cycle; released fields are scrambled.
    task automatic issue(input fccl_op_t o, input fccl_logic_fn_t f, input logic w, input logic [31:0] a, b);
        @(posedge aclk);
        upd_valid <= 1'h1;
        upd_req <= '{o, f, w, a, b};
        @(posedge aclk);
        upd_valid <= 1'h0;
        upd_req <= fccl_req_t'(~upd_req);
    endtask
    task automatic branch(output logic lt, eq);
        lt = cond.lt;
        eq = cond.eq;
    endtask
endmodule

// File: flag_condition_code_logic_test.sv
`timescale 1ns/1ps
module flag_condition_code_logic_test
    import fccl_pkg::*;
;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, lt, eq;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, rd;
    logic [1:0]  rs;
    wire logic   upd_valid, res_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire fccl_req_t   upd_req;
    wire fccl_flags_t live_flags;
    wire fccl_cond_t  cond;
    wire logic [31:0] res_data, s_axi_rdata;
    wire logic [15:0] keys_copy;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    int n_mismatch, cmp_count;
    logic [31:0] lres [4] = '{32'hF000F000, 32'hFFF0FFF0, 32'h0FF00FF0, 32'h0F0F0F0F};
    logic [31:0] ca [5] = '{32'h3, 32'h5, 32'h80000000, 32'h7FFFFFFF, 32'hFFFF};
    logic [31:0] cb [5] = '{32'h5, 32'h5, 32'h1, 32'h80000000, 32'h1};
    logic [1:0]  ce [5] = '{2'h2, 2'h1, 2'h2, 2'h0, 2'h2};

    fccl_flag_unit fccl_flag_unit_i (.aclk, .aresetn, .upd_valid, .upd_req, .res_valid, .res_data,
        .live_flags, .keys_copy, .cond, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp);
    fccl_datapath_model fccl_datapath_model_i (.aclk, .upd_valid, .upd_req, .cond);

    // ========
    // Tasks
    task chk(input logic [33:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task axw(input logic [3:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
        s_axi_awaddr <= ad; s_axi_wdata <= d;
        do @(posedge aclk); while (s_axi_awready !== 1'h1 || s_axi_wready !== 1'h1);
        s_axi_awvalid <= 1'h0; s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        rs = s_axi_bresp; s_axi_bready <= 1'h0;
    endtask
    task axr(input logic [3:0] ad);
        @(posedge aclk);
        s_axi_arvalid <= 1'h1; s_axi_araddr <= ad; s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 1'h0;
    endtask
    task op(input fccl_op_t o, input int f, input logic w, input logic [31:0] a, b, input logic [3:0] fl);
        fccl_datapath_model_i.issue(o, fccl_logic_fn_t'(f), w, a, b);
        #1;
        chk(live_flags, fl);
        chk(res_valid, o inside {op_add, op_sub, op_logic});
        @(posedge aclk);
        #1;
        chk(keys_copy, {fl[3], 1'h0, fl[2], 5'h00, fl[1], fl[0], 6'h00});
    endtask

    // ========
    // Sequence
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end
    initial begin
        aresetn = 1'h0; s_axi_awvalid = 1'h0; s_axi_wvalid = 1'h0; s_axi_bready = 1'h0;
        s_axi_arvalid = 1'h0; s_axi_rready = 1'h0; s_axi_awaddr = 4'h0; s_axi_araddr = 4'h0;
        s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        axr(FCCL_LIVE_OFS); chk({rs, rd}, 34'h0);
        op(op_add, 0, 1'h1, 32'h80000000, 32'h80000000, 4'hF); chk(res_data, 32'h0);
        axr(FCCL_KEYS_OFS); chk(rd, 32'hA0C0);
        fccl_datapath_model_i.branch(lt, eq); chk({lt, eq}, 2'h3);
        op(op_add, 0, 1'h0, 32'h7FFF, 32'h1, 4'h8); chk(res_data, 32'h8000);
        op(op_sub, 0, 1'h0, 32'h5, 32'h5, 4'h5); chk(res_data, 32'h0);
        op(op_sub, 0, 1'h1, 32'h0, 32'h1, 4'h2); chk(res_data, 32'hFFFFFFFF);
        for (int i = 0; i < 4; i++) begin
            op(op_logic, i, 1'h1, 32'hF0F0F0F0, 32'hFF00FF00, {2'h0, lres[i][31], 1'h0});
            chk(res_data, lres[i]);
        end
        op(op_logic, 1, 1'h0, 32'h8000, 32'h0, 4'h2);
        for (int i = 0; i < 5; i++) op(op_cmp, 0, i < 4, ca[i], cb[i], {2'h0, ce[i]});
        op(op_fault, 0, 1'h1, 32'h0, 32'h0, 4'hA);
        op(clear_overflow_flag_op, 0, 1'h1, 32'h0, 32'h0, 4'h2);
        op(set_overflow_flag_op, 0, 1'h1, 32'h0, 32'h0, 4'hA);
        op(accumulator_to_flags_op, 0, 1'h1, 32'hA0C0, 32'h0, 4'hF);
        op(load_status_word_op, 0, 1'h1, 32'h2000, 32'h0, 4'h4);
        axw(FCCL_CMD_OFS, 32'h00020000); axr(FCCL_LIVE_OFS); chk({rs, rd}, 34'hC);
        axw(FCCL_CMD_OFS, 32'h00010000); axr(FCCL_LIVE_OFS); chk({rs, rd}, 34'h4);
        axw(FCCL_CMD_OFS, 32'h0003A0C0); axr(FCCL_LIVE_OFS); chk(rd, 32'hF);
        axw(FCCL_KEYS_OFS, 32'h0); chk(rs, FCCL_RESP_SLV); axr(FCCL_KEYS_OFS); chk(rd, 32'hA0C0);
        axr(FCCL_COND_OFS); chk(rd[4:3], 2'h3);
        chk(rd, 32'h0000001A);
        axr(FCCL_CMD_OFS); chk(rd, 32'h0);
        axr(4'h6); chk({rs, rd}, {FCCL_RESP_SLV, 32'h0});
        conclude();
    end
endmodule
